// File: hdl/sss_params.svh
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define SSS_ADDR_W 4
`define SSS_OFS_TX_CTRL 4'h0
`define SSS_OFS_RX_CTRL 4'h1
`define SSS_OFS_TX_HOLD 4'h2
`define SSS_OFS_RX_DATA 4'h3
`define SSS_OFS_INT_STATUS 4'h4
`define SSS_OFS_INT_CLEAR 4'h5
`define SSS_OFS_INT_ENABLE 4'h6
`define SSS_OFS_FLAGS 4'h7

// ----------------------------------------------------------------
// transmit_status_control fields
// ----------------------------------------------------------------
`define SSS_TX_CLKSRC_BIT 7
`define SSS_TX_NINE_BIT 6
`define SSS_TX_EN_BIT 5
`define SSS_TX_SYNC_BIT 4
`define SSS_TX_TRMT_BIT 1
`define SSS_TX_D9_BIT 0
`define SSS_TX_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// receive_status_control fields
// ----------------------------------------------------------------
`define SSS_RX_PORT_EN_BIT 7
`define SSS_RX_NINE_BIT 6
`define SSS_RX_SINGLE_BIT 5
`define SSS_RX_CONT_BIT 4
`define SSS_RX_FERR_BIT 2
`define SSS_RX_OERR_BIT 1
`define SSS_RX_D9_BIT 0
`define SSS_RX_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// interrupt status layout, vector, timing
// ----------------------------------------------------------------
`define SSS_INT_TX_BIT 0
`define SSS_INT_RX_BIT 1
`define SSS_IRQ_VECTOR 16'h0020
`define SSS_CLK_PERIOD_NS 10
`define SSS_CK_PERIOD_NS 160
`define SSS_CK_HALF_CYC ((`SSS_CK_PERIOD_NS / `SSS_CLK_PERIOD_NS) / 2)

`endif

// File: hdl/sss_pkg.sv
`include "sss_params.svh"
package sss_pkg;

  typedef logic [`SSS_ADDR_W-1:0] sss_addr_type;
  typedef logic [8:0] sss_word_type;
  typedef logic [3:0] sss_count_type;
  typedef enum logic [1:0] {SSS_M_IDLE, SSS_M_HIGH, SSS_M_LOW} sss_mstate_type;

  // index of the last bit of a word: 8 bits or 9
  function automatic sss_count_type sss_last_bit(input logic nine);
    sss_last_bit = nine ? 4'h8 : 4'h7;
  endfunction : sss_last_bit

endpackage : sss_pkg

// File: hdl/sss_link_if.sv
`timescale 1ns/1ns
`default_nettype none

interface sss_link_if;
  logic ck;
  logic dt_dev_o;
  logic dt_dev_oe;
  logic dt_mst_o;
  logic dt_mst_oe;
  logic dt;

  // data wire resolved from the enables, pulled high when nobody drives
  assign dt = dt_dev_oe ? dt_dev_o : (dt_mst_oe ? dt_mst_o : 1'b1);

  modport device (input ck, input dt, output dt_dev_o, output dt_dev_oe);
  modport master (output ck, output dt_mst_o, output dt_mst_oe, input dt);
endinterface : sss_link_if

`default_nettype wire

// File: hdl/sss_slave_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "sss_params.svh"

module sss_slave_port (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // register port
  input wire logic [`SSS_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // core side
  input wire logic core_sleep,
  input wire logic global_int_enable,
  output logic irq,
  output logic wake,
  output logic [15:0] vector_addr,
  // link
  sss_link_if.device link
);

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  logic [7:0] tx_ctrl_r, rx_ctrl_r, hold_r, rx_buf_r, rdata_r;
  logic hold_full_r, tx_shift_full_r, rx_d9_r, rx_full_r, oerr_r;
  logic [8:0] tx_shift_r;
  sss_pkg::sss_count_type tx_cnt_r, rx_cnt_r;
  sss_pkg::sss_word_type rx_shift_r, rx_shift_nxt;
  logic [1:0] int_sts_r, int_en_r;
  logic [15:0] vector_r;
  logic ck_s1_r, ck_s2_r, ck_s3_r, dt_s1_r, dt_s2_r;
  logic clock_source_select, serial_port_enable, continuous_receive_enable, transmit_enable;
  logic slave_mode, tx_active, rx_active, ck_fall, tx_load, rx_done, rx_read, wr_hold, int_clr;
  assign clock_source_select = tx_ctrl_r[`SSS_TX_CLKSRC_BIT];
  assign serial_port_enable = rx_ctrl_r[`SSS_RX_PORT_EN_BIT];
  assign continuous_receive_enable = rx_ctrl_r[`SSS_RX_CONT_BIT];
  assign transmit_enable = tx_ctrl_r[`SSS_TX_EN_BIT];
  // no sleep term in the port enables: the shift clock comes from outside
  assign slave_mode = serial_port_enable & tx_ctrl_r[`SSS_TX_SYNC_BIT] & ~clock_source_select;
  assign tx_active = slave_mode & transmit_enable;
  // half duplex; single receive enable bit is never looked at
  assign rx_active = slave_mode & continuous_receive_enable & ~transmit_enable;
  assign ck_fall = ck_s3_r & ~ck_s2_r;
  assign tx_load = tx_active & hold_full_r & ~tx_shift_full_r;
  assign rx_done = rx_active & ck_fall & (rx_cnt_r == sss_pkg::sss_last_bit(rx_ctrl_r[`SSS_RX_NINE_BIT]));
  assign rx_read = reg_rd & (reg_addr == `SSS_OFS_RX_DATA);
  assign wr_hold = reg_wr & (reg_addr == `SSS_OFS_TX_HOLD);
  assign int_clr = reg_wr & (reg_addr == `SSS_OFS_INT_CLEAR);
  // ----------------------------------------------------------------
  // link synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
      dt_s1_r <= 1'b1;
      dt_s2_r <= 1'b1;
    end
    else
    begin
      ck_s1_r <= link.ck;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
      dt_s1_r <= link.dt;
      dt_s2_r <= dt_s1_r;
    end
  end
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_ctrl_r <= `SSS_TX_CTRL_RESET;
      rx_ctrl_r <= `SSS_RX_CTRL_RESET;
      int_en_r <= 2'h0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `SSS_OFS_TX_CTRL: tx_ctrl_r <= reg_wdata;
        `SSS_OFS_RX_CTRL: rx_ctrl_r <= reg_wdata;
        `SSS_OFS_INT_ENABLE: int_en_r <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // transmit holding buffer and shift register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      hold_r <= 8'h00;
      hold_full_r <= 1'b0;
    end
    else if (wr_hold)
    begin
      // a write may come before the enable, so the word waits here
      hold_r <= reg_wdata;
      hold_full_r <= 1'b1;
    end
    else if (tx_load)
      hold_full_r <= 1'b0;
  end
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_shift_r <= 9'h000;
      tx_shift_full_r <= 1'b0;
      tx_cnt_r <= 4'h0;
    end
    else if (tx_load)
    begin
      // ninth bit taken at load time
      tx_shift_r <= {tx_ctrl_r[`SSS_TX_D9_BIT], hold_r};
      tx_shift_full_r <= 1'b1;
      tx_cnt_r <= 4'h0;
    end
    else if (!tx_active)
    begin
      tx_shift_full_r <= 1'b0;
      tx_cnt_r <= 4'h0;
    end
    else if (tx_shift_full_r && ck_fall)
    begin
      // master samples on the falling edge, next bit follows it
      if (tx_cnt_r == sss_pkg::sss_last_bit(tx_ctrl_r[`SSS_TX_NINE_BIT]))
        tx_shift_full_r <= 1'b0;
      else
      begin
        tx_shift_r <= {1'b0, tx_shift_r[8:1]};
        tx_cnt_r <= tx_cnt_r + 4'h1;
      end
    end
  end
  assign link.dt_dev_o = tx_shift_r[0];
  assign link.dt_dev_oe = tx_active & tx_shift_full_r;
  // ----------------------------------------------------------------
  // receive shift register and buffer
  // ----------------------------------------------------------------
  always_comb
  begin
    rx_shift_nxt = rx_shift_r;
    rx_shift_nxt[rx_cnt_r] = dt_s2_r;
  end
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_shift_r <= 9'h000;
      rx_cnt_r <= 4'h0;
    end
    else if (!rx_active)
      rx_cnt_r <= 4'h0;
    else if (ck_fall)
    begin
      rx_shift_r <= rx_shift_nxt;
      rx_cnt_r <= rx_done ? 4'h0 : rx_cnt_r + 4'h1;
    end
  end
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_buf_r <= 8'h00;
      rx_d9_r <= 1'b0;
      rx_full_r <= 1'b0;
    end
    else if (rx_done && (!rx_full_r || rx_read))
    begin
      rx_buf_r <= rx_shift_nxt[7:0];
      rx_d9_r <= rx_ctrl_r[`SSS_RX_NINE_BIT] & rx_shift_nxt[8];
      rx_full_r <= 1'b1;
    end
    else if (rx_read)
      rx_full_r <= 1'b0;
  end
  // overrun: word lost while buffer still unread
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      oerr_r <= 1'b0;
    else if (!serial_port_enable || !continuous_receive_enable)
      oerr_r <= 1'b0;
    else if (rx_done && rx_full_r && !rx_read)
      oerr_r <= 1'b1;
  end
  // ----------------------------------------------------------------
  // interrupts and read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      int_sts_r <= 2'h0;
    else
    begin
      // set wins over a clear in the same cycle
      int_sts_r[`SSS_INT_TX_BIT] <= tx_load | (int_sts_r[`SSS_INT_TX_BIT] &
        ~(int_clr & reg_wdata[`SSS_INT_TX_BIT]));
      int_sts_r[`SSS_INT_RX_BIT] <= (rx_done & (~rx_full_r | rx_read)) | (int_sts_r[`SSS_INT_RX_BIT] &
        ~(int_clr & reg_wdata[`SSS_INT_RX_BIT]));
    end
  end
  assign irq = |(int_sts_r & int_en_r);
  assign wake = irq & core_sleep;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      vector_r <= 16'h0000;
    else
      vector_r <= (irq && global_int_enable) ? `SSS_IRQ_VECTOR : 16'h0000;
  end
  assign vector_addr = vector_r;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      rdata_r <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SSS_OFS_TX_CTRL: rdata_r <= {tx_ctrl_r[7:4], 2'b00, ~tx_shift_full_r, tx_ctrl_r[0]};
        `SSS_OFS_RX_CTRL: rdata_r <= {rx_ctrl_r[7:4], 1'b0, 1'b0, oerr_r, rx_d9_r};
        `SSS_OFS_RX_DATA: rdata_r <= rx_buf_r;
        `SSS_OFS_INT_STATUS: rdata_r <= {6'h00, int_sts_r};
        `SSS_OFS_INT_ENABLE: rdata_r <= {6'h00, int_en_r};
        `SSS_OFS_FLAGS: rdata_r <= {6'h00, rx_full_r, ~hold_full_r};
        default: rdata_r <= 8'h00;
      endcase
    end
    else
      rdata_r <= 8'h00;
  end
  assign reg_rdata = rdata_r;

endmodule : sss_slave_port

`default_nettype wire

// File: hdl/sss_master_end.sv
`timescale 1ns/1ns
`default_nettype none
`include "sss_params.svh"

module sss_master_end (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // user side
  input wire logic start,
  input wire logic send,
  input wire logic nine,
  input wire logic [8:0] wdata,
  output logic busy,
  output logic done,
  output logic [8:0] rdata,
  // link
  sss_link_if.master link
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam logic [7:0] HALF = 8'(`SSS_CK_HALF_CYC);
  sss_pkg::sss_mstate_type state_r;
  logic [7:0] div_r;
  sss_pkg::sss_count_type bit_r;
  logic [8:0] sh_r;
  logic [8:0] rdata_r;
  logic send_r;
  logic nine_r;
  logic ck_r;
  logic dt_r;
  logic done_r;
  logic dt_s1_r;
  logic dt_s2_r;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      dt_s1_r <= 1'b1;
      dt_s2_r <= 1'b1;
    end
    else
    begin
      dt_s1_r <= link.dt;
      dt_s2_r <= dt_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // shift clock divider and bit sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= sss_pkg::SSS_M_IDLE;
      div_r <= 8'h00;
      bit_r <= 4'h0;
      sh_r <= 9'h000;
      rdata_r <= 9'h000;
      send_r <= 1'b0;
      nine_r <= 1'b0;
      ck_r <= 1'b0;
      dt_r <= 1'b1;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      case (state_r)
        sss_pkg::SSS_M_IDLE:
        begin
          if (start)
          begin
            sh_r <= wdata;
            send_r <= send;
            nine_r <= nine;
            bit_r <= 4'h0;
            div_r <= HALF - 8'h01;
            ck_r <= 1'b1;
            dt_r <= wdata[0];
            state_r <= sss_pkg::SSS_M_HIGH;
          end
        end
        sss_pkg::SSS_M_HIGH:
        begin
          if (div_r == 8'h00)
          begin
            // slave sees this fall and only then moves its data
            ck_r <= 1'b0;
            rdata_r[bit_r] <= dt_s2_r;
            div_r <= HALF - 8'h01;
            state_r <= sss_pkg::SSS_M_LOW;
          end
          else
          begin
            div_r <= div_r - 8'h01;
          end
        end
        sss_pkg::SSS_M_LOW:
        begin
          if (div_r != 8'h00)
          begin
            div_r <= div_r - 8'h01;
          end
          else if (bit_r == sss_pkg::sss_last_bit(nine_r))
          begin
            dt_r <= 1'b1;
            done_r <= 1'b1;
            state_r <= sss_pkg::SSS_M_IDLE;
          end
          else
          begin
            bit_r <= bit_r + 4'h1;
            sh_r <= {1'b0, sh_r[8:1]};
            dt_r <= sh_r[1];
            ck_r <= 1'b1;
            div_r <= HALF - 8'h01;
            state_r <= sss_pkg::SSS_M_HIGH;
          end
        end
        default: state_r <= sss_pkg::SSS_M_IDLE;
      endcase
    end
  end

  assign link.ck = ck_r;
  assign link.dt_mst_o = dt_r;
  assign link.dt_mst_oe = send_r & (state_r != sss_pkg::SSS_M_IDLE);
  assign busy = state_r != sss_pkg::SSS_M_IDLE;
  assign done = done_r;
  assign rdata = rdata_r;

endmodule : sss_master_end

`default_nettype wire

// File: tb/sss_link_asserts.sv
`timescale 1ns/1ns
`default_nettype none

module sss_link_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // link wires
  input wire logic ck,
  input wire logic dt_dev_o,
  input wire logic dt_dev_oe,
  input wire logic dt_mst_o,
  input wire logic dt_mst_oe,
  input wire logic dt
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic ck_r;
  logic [3:0] since_fall_r;
  logic [3:0] falls_r;

  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      ck_r <= 1'b0;
    else
      ck_r <= ck;

  // saturates so a long idle gap never wraps into a legal window
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      since_fall_r <= 4'hf;
    else if (ck_r && !ck)
      since_fall_r <= 4'h0;
    else if (since_fall_r != 4'hf)
      since_fall_r <= since_fall_r + 4'h1;

  // shift clock falls seen while the port drives the data wire
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      falls_r <= 4'h0;
    else if (!dt_dev_oe)
      falls_r <= 4'h0;
    else if (ck_r && !ck)
      falls_r <= falls_r + 4'h1;

  // ----------------------------------------------------------------
  // link properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  a_no_drive_clash: assert property (!(dt_dev_oe && dt_mst_oe))
    else $error("both ends drive the data wire");
  a_ck_high_min: assert property ($rose(ck) |-> ck [*4])
    else $error("shift clock high half too short");
  a_ck_low_min: assert property ($fell(ck) |-> !ck [*4])
    else $error("shift clock low half too short");
  a_dev_bit_timing: assert property ((dt_dev_oe && $past(dt_dev_oe) && $changed(dt_dev_o)) |-> since_fall_r inside {[1:6]})
    else $error("port data changed away from a clock fall");
  a_word_length: assert property ($fell(dt_dev_oe) |-> (falls_r == 4'h8 || falls_r == 4'h9))
    else $error("sent word not eight or nine bits");
  a_dev_release: assert property ($fell(dt_dev_oe) |-> since_fall_r inside {[1:7]})
    else $error("port released data wire away from last fall");
  a_mst_bit_timing: assert property ((dt_mst_oe && $past(dt_mst_oe) && $changed(dt_mst_o)) |-> $rose(ck))
    else $error("master data changed away from a clock rise");
  a_dev_start_idle: assert property ($rose(dt_dev_oe) |-> !ck)
    else $error("port began driving in mid clock high");
  a_wire_idle_high: assert property ((!dt_dev_oe && !dt_mst_oe) |-> dt)
    else $error("undriven data wire not high");

endmodule : sss_link_asserts

`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sss_params.svh"

module tb_top;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic core_sleep = 1'b1;
  logic global_int_enable = 1'b1;
  logic irq;
  logic wake;
  logic [15:0] vector_addr;
  logic start = 1'b0;
  logic send = 1'b0;
  logic nine = 1'b0;
  logic [8:0] wdata = 9'h000;
  logic busy;
  logic done;
  logic [8:0] rdata;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  sss_link_if link();

  sss_slave_port u_sss_slave_port (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_sleep(core_sleep),
    .global_int_enable(global_int_enable), .irq(irq), .wake(wake), .vector_addr(vector_addr), .link(link));
  sss_master_end u_sss_master_end (.clock(clock), .resetn(resetn), .start(start), .send(send), .nine(nine),
    .wdata(wdata), .busy(busy), .done(done), .rdata(rdata), .link(link));
  sss_link_asserts u_sss_link_asserts (.clock(clock), .resetn(resetn), .ck(link.ck), .dt_dev_o(link.dt_dev_o),
    .dt_dev_oe(link.dt_dev_oe), .dt_mst_o(link.dt_mst_o), .dt_mst_oe(link.dt_mst_oe), .dt(link.dt));

  always #5 clock = ~clock;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic check_val(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check_val

  task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask : bus_write

  // read data stands only in the cycle after the strobe
  task automatic bus_read(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check_val({8'h00, reg_rdata}, {8'h00, exp});
  endtask : bus_read

  task automatic xfer(input logic s, input logic n, input logic [8:0] w);
    @(posedge clock);
    send <= s;
    nine <= n;
    wdata <= w;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
  endtask : xfer

  // also leaves time for the port's clock synchroniser to catch up
  task automatic xfer_wait();
    int i;
    for (i = 0; i < 400; i++)
    begin
      @(posedge clock);
      #1;
      if (done === 1'b1)
        break;
    end
    check_val({15'h0000, done}, 16'h0001);
    check_val({15'h0000, busy}, 16'h0000);
    repeat (6) @(posedge clock);
    #1;
  endtask : xfer_wait

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      num_errors++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    bus_read(`SSS_OFS_RX_CTRL, 8'h00);
    bus_read(`SSS_OFS_FLAGS, 8'h01);
    bus_read(`SSS_OFS_INT_STATUS, 8'h00);
    bus_read(4'h8, 8'h00);
    // receive asleep, single receive enable set but ignored
    bus_write(`SSS_OFS_INT_ENABLE, 8'h03);
    bus_write(`SSS_OFS_TX_CTRL, 8'h10);
    bus_write(`SSS_OFS_RX_CTRL, 8'hb0);
    xfer(1'b1, 1'b0, 9'h0a5);
    xfer_wait();
    check_val({15'h0000, irq}, 16'h0001);
    check_val({15'h0000, wake}, 16'h0001);
    check_val(vector_addr, 16'h0020);
    // awake core, interrupts masked globally: no wake, no vector
    @(posedge clock);
    global_int_enable <= 1'b0;
    core_sleep <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check_val(vector_addr, 16'h0000);
    check_val({15'h0000, wake}, 16'h0000);
    @(posedge clock);
    global_int_enable <= 1'b1;
    core_sleep <= 1'b1;
    bus_read(`SSS_OFS_RX_CTRL, 8'hb0);
    bus_read(`SSS_OFS_RX_DATA, 8'ha5);
    bus_read(`SSS_OFS_FLAGS, 8'h01);
    bus_write(`SSS_OFS_INT_CLEAR, 8'h02);
    check_val({15'h0000, irq}, 16'h0000);
    // nine-bit receive
    bus_write(`SSS_OFS_RX_CTRL, 8'hd0);
    xfer(1'b1, 1'b1, 9'h15a);
    xfer_wait();
    bus_read(`SSS_OFS_RX_CTRL, 8'hd1);
    bus_read(`SSS_OFS_RX_DATA, 8'h5a);
    // overrun latched until continuous receive is cleared
    xfer(1'b1, 1'b1, 9'h0ff);
    xfer_wait();
    xfer(1'b1, 1'b1, 9'h000);
    xfer_wait();
    bus_read(`SSS_OFS_RX_CTRL, 8'hd2);
    bus_read(`SSS_OFS_RX_DATA, 8'hff);
    bus_read(`SSS_OFS_RX_CTRL, 8'hd2);
    bus_write(`SSS_OFS_RX_CTRL, 8'hc0);
    bus_read(`SSS_OFS_RX_CTRL, 8'hc0);
    // abort in mid-word, then a clean word
    bus_write(`SSS_OFS_RX_CTRL, 8'h90);
    bus_write(`SSS_OFS_INT_CLEAR, 8'h03);
    xfer(1'b1, 1'b0, 9'h0ff);
    repeat (40) @(posedge clock);
    bus_write(`SSS_OFS_RX_CTRL, 8'h80);
    xfer_wait();
    bus_read(`SSS_OFS_INT_STATUS, 8'h00);
    bus_write(`SSS_OFS_RX_CTRL, 8'h90);
    xfer(1'b1, 1'b0, 9'h033);
    xfer_wait();
    bus_read(`SSS_OFS_INT_STATUS, 8'h02);
    bus_read(`SSS_OFS_RX_DATA, 8'h33);
    // two-word nine-bit transmit, loaded before enabling
    bus_write(`SSS_OFS_RX_CTRL, 8'h80);
    bus_write(`SSS_OFS_INT_CLEAR, 8'h03);
    bus_write(`SSS_OFS_TX_CTRL, 8'h51);
    bus_write(`SSS_OFS_TX_HOLD, 8'h5a);
    bus_read(`SSS_OFS_FLAGS, 8'h00);
    bus_write(`SSS_OFS_TX_CTRL, 8'h71);
    repeat (3) @(posedge clock);
    bus_read(`SSS_OFS_INT_STATUS, 8'h01);
    bus_write(`SSS_OFS_TX_HOLD, 8'hc3);
    bus_write(`SSS_OFS_INT_CLEAR, 8'h01);
    bus_read(`SSS_OFS_FLAGS, 8'h00);
    bus_read(`SSS_OFS_INT_STATUS, 8'h00);
    xfer(1'b0, 1'b1, 9'h000);
    xfer_wait();
    check_val({7'h00, rdata}, 16'h015a);
    check_val({15'h0000, wake}, 16'h0001);
    bus_read(`SSS_OFS_FLAGS, 8'h01);
    xfer(1'b0, 1'b1, 9'h000);
    xfer_wait();
    check_val({7'h00, rdata}, 16'h01c3);
    // masking drops the level but keeps the event
    bus_write(`SSS_OFS_INT_ENABLE, 8'h00);
    check_val({15'h0000, irq}, 16'h0000);
    bus_read(`SSS_OFS_INT_STATUS, 8'h01);
    give_verdict();
  end

endmodule : tb_top

`default_nettype wire
